// >>> hw/ufc_pkg.sv
// package: constants and types for the uart fifo control block
package ufc_pkg;
  // ---------------------------------------------------------------
  // field positions, fifo depth and error width
  // ---------------------------------------------------------------
  localparam int FC_EN_BIT    = 0;
  localparam int FC_RXFL_BIT  = 1;
  localparam int FC_TXFL_BIT  = 2;
  localparam int FC_DMA_BIT   = 3;
  localparam int FC_TXTRG_LSB = 4;
  localparam int FC_RXTRG_LSB = 6;
  localparam int FIFO_DEPTH   = 64;
  localparam int ERR_W        = 3;
  // ---------------------------------------------------------------
  // reset values and levels
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_RESET = 8'h00;
  localparam logic [6:0] RX_LVL0 = 7'h08;
  localparam logic [6:0] RX_LVL1 = 7'h10;
  localparam logic [6:0] RX_LVL2 = 7'h38;
  localparam logic [6:0] RX_LVL3 = 7'h3C;
  localparam logic [6:0] TX_LVL0 = 7'h08;
  localparam logic [6:0] TX_LVL1 = 7'h10;
  localparam logic [6:0] TX_LVL2 = 7'h20;
  localparam logic [6:0] TX_LVL3 = 7'h38;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic       dma_mode;
    logic       enable;
  } ufc_cfg_s;
  typedef struct packed {
    logic [ERR_W-1:0] err;
    logic [7:0]       data;
  } ufc_rx_word_s;
endpackage

// >>> hw/ufc_fifo.sv
// module: uart fifo control with parameterised fifo buffer
`timescale 1ns/100ps
module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  // control
  input  wire logic             i_flush,
  input  wire logic             i_single,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire logic        pop   = o_out_valid && i_out_ready;
  wire logic        full  = i_single ? ((count_reg != '0) && !pop) : (count_reg == (AW+1)'(DEPTH));
  wire logic        empty = (count_reg == '0);
  wire logic        push  = i_in_valid && o_in_ready;
  assign o_in_ready  = !full && !i_flush;
  assign o_out_valid = !empty && !i_flush;
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign o_count     = count_reg;
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
      count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // ufc_fifo

// ufc_top: fifo control register, tx and rx fifos, trigger outputs
module ufc_top #(
  parameter int DEPTH = ufc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // fifo_control write port
  input  wire logic        i_fc_we,
  input  wire logic [7:0]  i_fc_wdata,
  input  wire logic        i_enhanced_functions_enable,
  // host write to tx fifo
  input  wire logic        i_tx_valid,
  output logic             o_tx_ready,
  input  wire logic [7:0]  i_tx_data,
  // tx fifo to tx_shift_reg
  output logic             o_txs_valid,
  input  wire logic        i_txs_ready,
  output logic [7:0]       o_txs_data,
  // rx_shift_reg to rx fifo
  input  wire logic        i_rxs_valid,
  input  wire logic [7:0]  i_rxs_data,
  input  wire logic [2:0]  i_rxs_err,
  // host read from rx fifo
  output logic             o_rx_valid,
  input  wire logic        i_rx_ready,
  output logic [7:0]       o_rx_data,
  output logic [2:0]       o_rx_err,
  // status
  output logic             o_fifo_enable,
  output logic             o_dma_mode,
  output logic             o_rx_trigger,
  output logic             o_tx_trigger,
  output logic             o_rx_flushing,
  output logic             o_tx_flushing
);
  localparam int AW = $clog2(DEPTH);
  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  ufc_pkg::ufc_cfg_s cfg_reg;
  ufc_pkg::ufc_cfg_s cfg_next;
  logic              txfl_reg;
  logic              rxfl_reg;
  wire logic txfl_set = i_fc_we && i_fc_wdata[ufc_pkg::FC_TXFL_BIT];
  wire logic rxfl_set = i_fc_we && i_fc_wdata[ufc_pkg::FC_RXFL_BIT];
  always_comb begin
    cfg_next = cfg_reg;
    if (i_fc_we) begin
      cfg_next.enable   = i_fc_wdata[ufc_pkg::FC_EN_BIT];
      cfg_next.dma_mode = i_fc_wdata[ufc_pkg::FC_DMA_BIT];
      cfg_next.rx_trig  = i_fc_wdata[ufc_pkg::FC_RXTRG_LSB +: 2];
      if (i_enhanced_functions_enable) begin
        cfg_next.tx_trig = i_fc_wdata[ufc_pkg::FC_TXTRG_LSB +: 2];
      end
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg  <= ufc_pkg::ufc_cfg_s'(ufc_pkg::FC_RESET[5:0]);
      txfl_reg <= 1'b0;
      rxfl_reg <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      txfl_reg <= txfl_set;                                                   // self-clear
      rxfl_reg <= rxfl_set;                                                   // self-clear
    end
  end
  assign o_fifo_enable = cfg_reg.enable;
  assign o_dma_mode    = cfg_reg.dma_mode;
  assign o_tx_flushing = txfl_reg;
  assign o_rx_flushing = rxfl_reg;
  // ---------------------------------------------------------------
  // level decode
  // ---------------------------------------------------------------
  function automatic logic [6:0] lvl(input logic [1:0] sel, input logic rx);
    unique case (sel)
      2'b00: lvl = rx ? ufc_pkg::RX_LVL0 : ufc_pkg::TX_LVL0;
      2'b01: lvl = rx ? ufc_pkg::RX_LVL1 : ufc_pkg::TX_LVL1;
      2'b10: lvl = rx ? ufc_pkg::RX_LVL2 : ufc_pkg::TX_LVL2;
      2'b11: lvl = rx ? ufc_pkg::RX_LVL3 : ufc_pkg::TX_LVL3;
    endcase
  endfunction
  // ---------------------------------------------------------------
  // fifos; flushes touch only fifo state, never the shift registers
  // ---------------------------------------------------------------
  logic [AW:0] tx_cnt;
  logic [AW:0] rx_cnt;
  ufc_pkg::ufc_rx_word_s rx_word;
  wire logic   single = !cfg_reg.enable;
  ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_flush    (txfl_reg),
    .i_single   (single),
    .i_in_valid (i_tx_valid),
    .o_in_ready (o_tx_ready),
    .i_in_data  (i_tx_data),
    .o_out_valid(o_txs_valid),
    .i_out_ready(i_txs_ready),
    .o_out_data (o_txs_data),
    .o_count    (tx_cnt)
  );
  // single mode: the held character is popped so the new one takes its place
  wire logic rx_drop = single && i_rxs_valid && o_rx_valid && !i_rx_ready;
  ufc_fifo #(.WIDTH(8 + ufc_pkg::ERR_W), .DEPTH(DEPTH)) u_rx (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_flush    (rxfl_reg),
    .i_single   (single),
    .i_in_valid (i_rxs_valid),
    .o_in_ready (),
    .i_in_data  ({i_rxs_err, i_rxs_data}),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready || rx_drop),
    .o_out_data (rx_word),
    .o_count    (rx_cnt)
  );
  assign o_rx_data = rx_word.data;
  assign o_rx_err  = rx_word.err;
  // ---------------------------------------------------------------
  // trigger indications
  // ---------------------------------------------------------------
  wire logic [AW:0] tx_free = (AW+1)'(DEPTH) - tx_cnt;
  assign o_rx_trigger = cfg_reg.enable && ((AW+1)'(rx_cnt) >= (AW+1)'(lvl(cfg_reg.rx_trig, 1'b1)));
  assign o_tx_trigger = cfg_reg.enable && (tx_free >= (AW+1)'(lvl(cfg_reg.tx_trig, 1'b0)));
endmodule // ufc_top

// >>> verif/ufc_monitor.sv
// checker: fifo control port assertions
`timescale 1ns/100ps
module ufc_monitor (
  input wire logic       i_clk_sys, i_rst_n, i_fc_we,
  input wire logic [7:0] i_fc_wdata,
  input wire logic       o_tx_flushing, o_rx_flushing, o_fifo_enable, o_dma_mode,
  input wire logic       o_tx_ready, o_txs_valid, o_rx_valid, o_rx_trigger, o_tx_trigger
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence tx_pulse; o_tx_flushing ##1 !o_tx_flushing; endsequence
  sequence rx_pulse; o_rx_flushing ##1 !o_rx_flushing; endsequence
  tx_flush_a: assert property (i_fc_we && i_fc_wdata[2] |=> tx_pulse)
    else $error("tx flush pulse wrong");
  rx_flush_a: assert property (i_fc_we && i_fc_wdata[1] |=> rx_pulse)
    else $error("rx flush pulse wrong");
  tx_noflush_a: assert property (i_fc_we && !i_fc_wdata[2] |=> !o_tx_flushing)
    else $error("tx flush without request");
  enable_set_a: assert property (i_fc_we |=> o_fifo_enable == $past(i_fc_wdata[0]))
    else $error("fifo enable not taken");
  dma_set_a: assert property (i_fc_we |=> o_dma_mode == $past(i_fc_wdata[3]))
    else $error("dma mode not taken");
  cfg_hold_a: assert property (!i_fc_we |=> $stable(o_fifo_enable) && $stable(o_dma_mode))
    else $error("config changed without write");
  tx_block_a: assert property (o_tx_flushing |-> !o_tx_ready && !o_txs_valid)
    else $error("tx handshake during flush");
  tx_empty_a: assert property (o_tx_flushing |=> !o_txs_valid)
    else $error("tx fifo not empty after flush");
  rx_block_a: assert property (o_rx_flushing |-> !o_rx_valid)
    else $error("rx valid during flush");
  trig_off_a: assert property (!o_fifo_enable |-> !o_rx_trigger && !o_tx_trigger)
    else $error("trigger while disabled");
endmodule // ufc_monitor

// >>> verif/ufc_txs_model.sv
// model: tx shift register taking bytes from the tx fifo head
`timescale 1ns/100ps
module ufc_txs_model (
  input wire logic       i_clk_sys, i_rst_n, i_stall, i_valid,
  input wire logic [7:0] i_data,
  output logic           o_ready,
  output logic [7:0]     o_last
);
  assign o_ready = !i_stall;
  // byte once taken stays whatever the fifo does
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) o_last <= 8'hA5;
    else if (i_valid && o_ready) o_last <= i_data;
  end
endmodule // ufc_txs_model

// >>> verif/uart_fifo_control_tb_top.sv
// testbench: fifo control register, triggers, flush, disabled mode
`timescale 1ns/100ps
module uart_fifo_control_tb_top;
  typedef struct packed {logic e; logic [7:0] d; logic en; logic dma;} ufc_row_s;
  logic clk = 0, rst_n = 0, we = 0, eff = 0, tx_v = 0, txs_rdy, stall = 1, rxs_v = 0, rx_rdy = 0;
  logic [7:0] wd = 8'h00, txd = 8'h00, rxsd = 8'h00, txs_d, rx_d, last;
  logic [2:0] rxse = 3'h0, rx_e;
  logic en, dma, rx_t, tx_t, rxf, txf, tx_rdy, txs_v, rx_v;
  int miscompares = 0, total_checks = 0, cyc = 0;
  logic [6:0] rlv [4] = '{ufc_pkg::RX_LVL0, ufc_pkg::RX_LVL1, ufc_pkg::RX_LVL2, ufc_pkg::RX_LVL3};
  logic [6:0] tlv [4] = '{ufc_pkg::TX_LVL0, ufc_pkg::TX_LVL1, ufc_pkg::TX_LVL2, ufc_pkg::TX_LVL3};
  ufc_row_s rows [4] = '{'{1'b0, 8'h01, 1'b1, 1'b0}, '{1'b0, 8'h09, 1'b1, 1'b1},
                         '{1'b0, 8'h08, 1'b0, 1'b1}, '{1'b1, 8'h01, 1'b1, 1'b0}};
  ufc_top #(.DEPTH(64)) DUT (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_fc_we(we), .i_fc_wdata(wd), .i_enhanced_functions_enable(eff),
    .i_tx_valid(tx_v), .o_tx_ready(tx_rdy), .i_tx_data(txd), .o_txs_valid(txs_v), .i_txs_ready(txs_rdy),
    .o_txs_data(txs_d), .i_rxs_valid(rxs_v), .i_rxs_data(rxsd), .i_rxs_err(rxse), .o_rx_valid(rx_v),
    .i_rx_ready(rx_rdy), .o_rx_data(rx_d), .o_rx_err(rx_e), .o_fifo_enable(en), .o_dma_mode(dma),
    .o_rx_trigger(rx_t), .o_tx_trigger(tx_t), .o_rx_flushing(rxf), .o_tx_flushing(txf));
  ufc_txs_model u_txs (.i_clk_sys(clk), .i_rst_n(rst_n), .i_stall(stall), .i_valid(txs_v),
    .i_data(txs_d), .o_ready(txs_rdy), .o_last(last));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(logic e, logic [7:0] d);
    @(posedge clk); #1 we = 1; wd = d; eff = e;
    @(posedge clk); #1 we = 0;
  endtask
  task push(logic rx, int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk); #1 {rxs_v, tx_v} = rx ? 2'b10 : 2'b01; txd = i[7:0]; rxsd = i[7:0]; rxse = ~i[2:0];
    end
    @(posedge clk); #1 {rxs_v, tx_v} = 2'b00;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    chk("enable", 8'h00, en); chk("dma", 8'h00, dma); chk("flushing", 8'h00, {txf, rxf});
    chk("tx_ready", 8'h01, tx_rdy);
    foreach (rows[k]) begin
      wr(rows[k].e, rows[k].d);
      chk("enable", rows[k].en, en);
      chk("dma", rows[k].dma, dma);
    end
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, {k[1:0], 6'h03});
      push(1'b1, rlv[k] - 1);
      chk("rx_trig_below", 8'h00, rx_t);
      push(1'b1, 1);
      chk("rx_trig_at", 8'h01, rx_t);
      chk("rx_head", 8'h00, rx_d); chk("rx_err", 8'h07, rx_e);
    end
    @(posedge clk); #1 rx_rdy = 1;
    @(posedge clk); #1 rx_rdy = 0;
    chk("rx_next", 8'h01, rx_d);
    for (int k = 0; k < 4; k++) begin
      wr(1'b1, {2'b00, k[1:0], 4'h5});
      push(1'b0, 64 - tlv[k]);
      chk("tx_trig_at", 8'h01, tx_t);
      push(1'b0, 1);
      chk("tx_trig_below", 8'h00, tx_t);
    end
    push(1'b0, 55);
    chk("tx_ready_full", 8'h00, tx_rdy);
    @(posedge clk); #1 stall = 0;
    @(posedge clk); #1 stall = 1;
    chk("shift_byte", 8'h00, last);
    wr(1'b0, 8'h05);
    chk("shift_kept", 8'h00, last); chk("tx_empty", 8'h00, txs_v);
    push(1'b0, 9);
    chk("tx_trig_gated", 8'h00, tx_t);
    wr(1'b0, 8'h06);
    push(1'b0, 1);
    chk("tx_single", 8'h00, tx_rdy);
    push(1'b1, 1);
    chk("rx_single", 8'h00, rx_d); chk("rx_valid", 8'h01, rx_v);
    @(posedge clk); #1 rxs_v = 1; rxsd = 8'h5A;
    @(posedge clk); #1 rxs_v = 0;
    chk("rx_overwrite", 8'h5A, rx_d); chk("rx_valid_ow", 8'h01, rx_v);
    chk("trig_off", 8'h00, {rx_t, tx_t});
    tally_and_finish();
  end
endmodule // uart_fifo_control_tb_top
bind ufc_top ufc_monitor u_mon (.*);
